// >>> hw/tcrs_map.vh
// constants for the totaliser clip-off, reset and security block
// assumes a 25 MHz clock and a 32-bit axi4-lite register bus
`ifndef TCRS_MAP_VH
`define TCRS_MAP_VH
// register byte offsets
`define TCRS_CTRL_OFS      8'h00
`define TCRS_CLIP_OFS      8'h04
`define TCRS_DIV_OFS       8'h08
`define TCRS_SCALE_OFS     8'h0c
`define TCRS_TB_OFS        8'h10
`define TCRS_DP_OFS        8'h14
`define TCRS_CODE_OFS      8'h18
`define TCRS_STAT_OFS      8'h1c
`define TCRS_IRQ_OFS       8'h20
`define TCRS_MASK_OFS      8'h24
`define TCRS_RATE_OFS      8'h28
`define TCRS_TOT_OFS       8'h2c
`define TCRS_GT_LO_OFS     8'h30
`define TCRS_GT_HI_OFS     8'h34
`define TCRS_CONFIRM_OFS   8'h38
`define TCRS_GATE_OFS      8'h3c
// control bit positions
`define TCRS_CTRL_TOT_EN   0
`define TCRS_CTRL_GT_EN    1
`define TCRS_CTRL_CFG      2
// interrupt bit positions
`define TCRS_IRQ_TOT_CLR   0
`define TCRS_IRQ_GT_CLR    1
`define TCRS_IRQ_HOLD      2
// confirmation word for the menu grand clear
`define TCRS_CONFIRM_WORD  16'h5a7e
// default access code, all zero means open access
`define TCRS_CODE_DEFAULT  16'h0000
// timebase multipliers
`define TCRS_TB_SEC        12'h001
`define TCRS_TB_MIN        12'h03c
`define TCRS_TB_HOUR       12'he10
// timing in milliseconds, clock rate in kilohertz
`define TCRS_ACT_MS        2000
`define TCRS_TOT_HOLD_MS   3000
`define TCRS_GT_HOLD_MS    10000
`define TCRS_REM_HOLD_MS   1000
`define TCRS_CLK_KHZ       25000
`endif

// >>> hw/tcrs_top.v
// totaliser clip-off, panel/remote reset, grand total and access code
// assumes async pins (buttons, terminals, pulse) and an axi4-lite master
// How it works
// - below clip-off: zero rate, hold, no count
// - activity indicator runs two seconds per pulse
// - scaling changes force clip-off to zero
// - clip-off compared in rate display units
// - stored panel total clear enable
// - both buttons over three seconds clear total
// - terminals shorted over one second clear total
// - sixteen digit grand total, survives total clears
// - grand total read as two eight-digit halves
// - stored panel grand clear enable
// - both buttons over ten seconds clear grand
// - menu grand clear needs yes plus word
// - grand clear keeps no old copy
// - four digit code gates configuration
// - default code gives unrestricted access
// - new code active on return to totalising
// - rate is pulses over divisors times timebase
`timescale 1ns/1ps
`include "tcrs_map.vh"
module tcrs_top #(
  parameter ACT_CYC  = (`TCRS_ACT_MS * `TCRS_CLK_KHZ),
  parameter TOT_CYC  = (`TCRS_TOT_HOLD_MS * `TCRS_CLK_KHZ) + 1,
  parameter GT_CYC   = (`TCRS_GT_HOLD_MS * `TCRS_CLK_KHZ) + 1,
  parameter REM_CYC  = (`TCRS_REM_HOLD_MS * `TCRS_CLK_KHZ) + 1,
  parameter GATE_CYC = 25000000
) (
  input  wire        clock,
  input  wire        reset_n,
  input  wire        pulse_in,
  input  wire        button_a_n,
  input  wire        button_b_n,
  input  wire        remote_clear_terminal_a,
  input  wire        remote_clear_terminal_b,
  output reg         hold_annunciator_q,
  output reg         flow_active_q,
  output reg         irq_q,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready
);

////////////////////////////////////////////////////////////////////////////////
// reset release and pin synchronisers
reg        rst_a_q;    // first reset stage
reg        rst_b_q;    // released reset copy
wire       rst_n = rst_b_q;
reg  [4:0] sync1_q;    // first stage, read only by sync2_q
reg  [4:0] sync2_q;    // usable pin levels, pulse in bit 4

// reset asserts at once, releases after two edges
always @(posedge clock or negedge reset_n) begin
  if (!reset_n) begin
    rst_a_q <= 1'b0;
    rst_b_q <= 1'b0;
  end else begin
    rst_a_q <= 1'b1;
    rst_b_q <= rst_a_q;
  end
end

// two flops on every async pin
always @(posedge clock or negedge rst_n) begin
  if (!rst_n) begin
    sync1_q <= 5'h00;
    sync2_q <= 5'h00;
  end else begin
    sync1_q <= {pulse_in, remote_clear_terminal_b, remote_clear_terminal_a,
                ~button_b_n, ~button_a_n};
    sync2_q <= sync1_q;
  end
end

wire buttons_both = sync2_q[0] & sync2_q[1];
// terminals shorted: both read high through the bench's contact model
wire remote_short = sync2_q[2] & sync2_q[3];
reg  pin_pulse_q;      // synchronised pulse input
wire pulse_edge;

////////////////////////////////////////////////////////////////////////////////
// registers
reg  [2:0]  ctrl_q;       // total enable, grand enable, config mode
reg  [31:0] clip_q;       // low_flow_cutoff_threshold
reg  [31:0] div_q;        // pulse_divisor
reg  [31:0] scale_q;      // rate_scale_divisor
reg  [1:0]  tb_q;         // rate_time_multiplier select
reg  [3:0]  dp_q;         // rate decimal point position
reg  [15:0] code_new_q;   // access_code as written
reg  [15:0] code_act_q;   // access code in force
reg  [15:0] entry_q;      // operator code entry
reg  [2:0]  irq_stat_q;   // sticky events
reg  [2:0]  irq_mask_q;   // interrupt enables
reg  [31:0] rate_q;       // displayed rate
reg  [31:0] total_q;      // resettable total
reg  [63:0] grand_q;      // sixteen bcd digits
reg  [15:0] confirm_q;    // confirmation word entry
reg  [31:0] pcount_q;     // pulses in current gate
reg  [31:0] gate_q;       // gate timer
reg  [31:0] act_q;        // activity timer
reg  [31:0] tot_hold_q;   // panel total hold timer
reg  [31:0] gt_hold_q;    // panel grand hold timer
reg  [31:0] rem_hold_q;   // remote hold timer
reg         cfg_prev_q;   // last config mode
reg  [1:0]  wr_st_q;      // write address/data captured
reg  [7:0]  waddr_q;
reg  [31:0] wdata_q;

wire wr_go = (wr_st_q == 2'b11) & ~s_axi_bvalid;
wire [7:0] wa = waddr_q;
wire cfg_granted = (code_act_q == `TCRS_CODE_DEFAULT) | (entry_q == code_act_q);
wire cfg_ok      = ctrl_q[`TCRS_CTRL_CFG] & cfg_granted;
wire grand_req   = wr_go & cfg_ok & (wa == `TCRS_CONFIRM_OFS) & wdata_q[16];

// timebase multiplier
reg [11:0] tb_mul;
always @* begin
  case (tb_q)
    2'd1:    tb_mul = `TCRS_TB_MIN;
    2'd2:    tb_mul = `TCRS_TB_HOUR;
    default: tb_mul = `TCRS_TB_SEC;
  endcase
end

////////////////////////////////////////////////////////////////////////////////
// rate measurement
// rate from gated count
wire [63:0] rate_num = {32'h0, pcount_q} * {52'h0, tb_mul};
wire [63:0] rate_den = ({32'h0, div_q} * {32'h0, scale_q});
wire [63:0] rate_raw = (rate_den == 64'h0) ? 64'h0 : rate_num / rate_den;
wire below_clip = (rate_raw[63:32] == 32'h0) && (rate_raw[31:0] < clip_q);
wire gate_end   = (gate_q >= GATE_CYC - 1);
assign pulse_edge = sync2_q[4] & ~pin_pulse_q;

// gate one second, latch rate
always @(posedge clock or negedge rst_n) begin
  if (!rst_n) begin
    pin_pulse_q        <= 1'b0;
    gate_q             <= 32'h0;
    pcount_q           <= 32'h0;
    rate_q             <= 32'h0;
    hold_annunciator_q <= 1'b1;
  end else begin
    pin_pulse_q <= sync2_q[4];
    if (gate_end) begin
      gate_q   <= 32'h0;
      pcount_q <= {31'h0, pulse_edge};
      rate_q             <= below_clip ? 32'h0 : rate_raw[31:0];
      hold_annunciator_q <= below_clip;
    end else begin
      gate_q   <= gate_q + 32'h1;
      pcount_q <= pcount_q + {31'h0, pulse_edge};
    end
  end
end

always @(posedge clock or negedge rst_n) begin
  if (!rst_n) begin
    act_q         <= 32'h0;
    flow_active_q <= 1'b0;
  end else begin
    if (pulse_edge)
      act_q <= ACT_CYC;
    else if (act_q != 32'h0)
      act_q <= act_q - 32'h1;
    flow_active_q <= pulse_edge | (act_q > 32'h1);
  end
end

////////////////////////////////////////////////////////////////////////////////
// hold timers
wire tot_mode = ~ctrl_q[`TCRS_CTRL_CFG];
wire tot_run = tot_mode & ctrl_q[`TCRS_CTRL_TOT_EN] & buttons_both;
wire gt_run  = tot_mode & ctrl_q[`TCRS_CTRL_GT_EN] & buttons_both;
wire tot_fire = tot_run & (tot_hold_q == TOT_CYC - 1);
wire gt_fire  = gt_run & (gt_hold_q == GT_CYC - 1);
wire rem_fire = remote_short & (rem_hold_q == REM_CYC - 1);

// timers restart on any release, fire once per hold
always @(posedge clock or negedge rst_n) begin
  if (!rst_n) begin
    tot_hold_q <= 32'h0;
    gt_hold_q  <= 32'h0;
    rem_hold_q <= 32'h0;
  end else begin
    tot_hold_q <= !tot_run ? 32'h0 : (tot_hold_q < TOT_CYC) ? tot_hold_q + 32'h1 : tot_hold_q;
    gt_hold_q  <= !gt_run ? 32'h0 : (gt_hold_q < GT_CYC) ? gt_hold_q + 32'h1 : gt_hold_q;
    rem_hold_q <= !remote_short ? 32'h0 :
                  (rem_hold_q < REM_CYC) ? rem_hold_q + 32'h1 : rem_hold_q;
  end
end

////////////////////////////////////////////////////////////////////////////////
// total and grand total
// bcd increment of sixteen digits
reg [63:0] grand_inc;
reg        carry;
integer    i;
always @* begin
  carry = 1'b1;
  grand_inc = grand_q;
  for (i = 0; i < 16; i = i + 1) begin
    if (carry) begin
      if (grand_q[i*4 +: 4] == 4'h9) begin
        grand_inc[i*4 +: 4] = 4'h0;
      end else begin
        grand_inc[i*4 +: 4] = grand_q[i*4 +: 4] + 4'h1;
        carry = 1'b0;
      end
    end
  end
end

wire count_en = pulse_edge & ~hold_annunciator_q;

// counts advance together, clears are separate
always @(posedge clock or negedge rst_n) begin
  if (!rst_n) begin
    total_q <= 32'h0;
    grand_q <= 64'h0;
  end else begin
    if (tot_fire | rem_fire)
      total_q <= 32'h0;
    else if (count_en)
      total_q <= total_q + 32'h1;
    if (gt_fire | (grand_req & (confirm_q == `TCRS_CONFIRM_WORD)))
      grand_q <= 64'h0;
    else if (count_en)
      grand_q <= grand_inc;
  end
end

////////////////////////////////////////////////////////////////////////////////
// axi4-lite write side
wire stat_w1c = wr_go & (wa == `TCRS_IRQ_OFS);
// hold entry is an edge, so a w1c clear sticks while hold stays up
wire [2:0] events = {gate_end & below_clip & ~hold_annunciator_q,
                     gt_fire, tot_fire | rem_fire};
wire scal_chg = wr_go & cfg_ok & ((wa == `TCRS_DIV_OFS) | (wa == `TCRS_SCALE_OFS) |
                (wa == `TCRS_TB_OFS) | (wa == `TCRS_DP_OFS));

// capture address and data in either order, answer once both held
always @(posedge clock or negedge rst_n) begin
  if (!rst_n) begin
    wr_st_q       <= 2'b00;
    waddr_q       <= 8'h00;
    wdata_q       <= 32'h0;
    s_axi_awready <= 1'b0;
    s_axi_wready  <= 1'b0;
    s_axi_bvalid  <= 1'b0;
    s_axi_bresp   <= 2'b00;
  end else begin
    s_axi_awready <= ~wr_st_q[0] & ~s_axi_awready & s_axi_awvalid;
    s_axi_wready  <= ~wr_st_q[1] & ~s_axi_wready & s_axi_wvalid;
    if (s_axi_awvalid & s_axi_awready) begin
      wr_st_q[0] <= 1'b1;
      waddr_q    <= s_axi_awaddr;
    end
    if (s_axi_wvalid & s_axi_wready) begin
      wr_st_q[1] <= 1'b1;
      wdata_q    <= s_axi_wdata;
    end
    if (wr_go) begin
      wr_st_q      <= 2'b00;
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wa > `TCRS_GATE_OFS) ? 2'b10 : 2'b00;
    end else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end
end

// register stores; strobes ignored, full words only
always @(posedge clock or negedge rst_n) begin
  if (!rst_n) begin
    ctrl_q     <= 3'h0;
    clip_q     <= 32'h0;
    div_q      <= 32'h1;
    scale_q    <= 32'h1;
    tb_q       <= 2'h0;
    dp_q       <= 4'h0;
    code_new_q <= `TCRS_CODE_DEFAULT;
    code_act_q <= `TCRS_CODE_DEFAULT;
    entry_q    <= 16'h0;
    confirm_q  <= 16'h0;
    irq_mask_q <= 3'h0;
    irq_stat_q <= 3'h0;
    cfg_prev_q <= 1'b0;
    irq_q      <= 1'b0;
  end else begin
    cfg_prev_q <= ctrl_q[`TCRS_CTRL_CFG];
    // code takes effect on leaving config
    if (cfg_prev_q & ~ctrl_q[`TCRS_CTRL_CFG])
      code_act_q <= code_new_q;
    if (wr_go) begin
      case (wa)
        `TCRS_CTRL_OFS: ctrl_q <= wdata_q[2:0];
        `TCRS_GATE_OFS: entry_q <= wdata_q[15:0];
        `TCRS_MASK_OFS: irq_mask_q <= wdata_q[2:0];
        `TCRS_CONFIRM_OFS: confirm_q <= wdata_q[15:0];
        default: ;
      endcase
      if (cfg_ok) begin
        case (wa)
          `TCRS_CLIP_OFS:  clip_q <= wdata_q;
          `TCRS_DIV_OFS:   div_q <= wdata_q;
          `TCRS_SCALE_OFS: scale_q <= wdata_q;
          `TCRS_TB_OFS:    tb_q <= wdata_q[1:0];
          `TCRS_DP_OFS:    dp_q <= wdata_q[3:0];
          `TCRS_CODE_OFS:  code_new_q <= wdata_q[15:0];
          default: ;
        endcase
      end
    end
    if (scal_chg)
      clip_q <= 32'h0;
    // set wins over write-one clear
    irq_stat_q <= (irq_stat_q & ~(stat_w1c ? wdata_q[2:0] : 3'h0)) | events;
    irq_q      <= |(irq_stat_q & irq_mask_q);
  end
end

////////////////////////////////////////////////////////////////////////////////
// axi4-lite read side
reg [31:0] rd_mux;
always @* begin
  case (s_axi_araddr)
    `TCRS_CTRL_OFS:    rd_mux = {29'h0, ctrl_q};
    `TCRS_CLIP_OFS:    rd_mux = clip_q;
    `TCRS_DIV_OFS:     rd_mux = div_q;
    `TCRS_SCALE_OFS:   rd_mux = scale_q;
    `TCRS_TB_OFS:      rd_mux = {30'h0, tb_q};
    `TCRS_DP_OFS:      rd_mux = {28'h0, dp_q};
    `TCRS_CODE_OFS:    rd_mux = 32'h0;
    `TCRS_STAT_OFS:    rd_mux = {29'h0, cfg_granted, flow_active_q, hold_annunciator_q};
    `TCRS_IRQ_OFS:     rd_mux = {29'h0, irq_stat_q};
    `TCRS_MASK_OFS:    rd_mux = {29'h0, irq_mask_q};
    `TCRS_RATE_OFS:    rd_mux = rate_q;
    `TCRS_TOT_OFS:     rd_mux = total_q;
    `TCRS_GT_LO_OFS:   rd_mux = grand_q[31:0];
    `TCRS_GT_HI_OFS:   rd_mux = grand_q[63:32];
    default:           rd_mux = 32'h0;
  endcase
end

// one read at a time, answer the cycle after arready
always @(posedge clock or negedge rst_n) begin
  if (!rst_n) begin
    s_axi_arready <= 1'b0;
    s_axi_rvalid  <= 1'b0;
    s_axi_rdata   <= 32'h0;
    s_axi_rresp   <= 2'b00;
  end else begin
    s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
    if (s_axi_arvalid & s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= (s_axi_araddr > `TCRS_GATE_OFS) ? 2'b10 : 2'b00;
    end else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
end

endmodule

// >>> tb/tcrs_props.sv
// checker for the totaliser control block, watching top-level ports only
// assumes a single clock domain; reset_n low disables every property
`timescale 1ns/1ps
module tcrs_props #(
  parameter ACT_CYC = 20
) (
  input wire        clock,
  input wire        reset_n,
  input wire        pulse_in,
  input wire        flow_active_q,
  input wire        hold_annunciator_q,
  input wire        irq_q,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [1:0]  s_axi_bresp,
  input wire [7:0]  s_axi_araddr,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////////////////////
  // cycles since the last pulse edge; saturates so long idle spans stay sane
  reg [31:0] gap_q;
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) gap_q <= 32'hffffffff;
    else if ($rose(pulse_in)) gap_q <= 32'h00000000;
    else if (gap_q != 32'hffffffff) gap_q <= gap_q + 32'h00000001;
  end
  ////////////////////////////////////////////////////////////////////////////////
  property p_act_rise; $rose(pulse_in) |-> ##[1:6] flow_active_q; endproperty
  a_act_rise: assert property (p_act_rise) else $error("indicator late");
  property p_act_hold; $rose(flow_active_q) |-> flow_active_q [*8]; endproperty
  a_act_hold: assert property (p_act_hold) else $error("indicator short");
  // the fall must come one full interval after the last pulse, sync delay aside
  property p_act_fall;
    $fell(flow_active_q) |-> (gap_q >= ACT_CYC) && (gap_q <= ACT_CYC + 8);
  endproperty
  a_act_fall: assert property (p_act_fall) else $error("indicator fall off");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  property p_r_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_r_lat: assert property (p_r_lat) else $error("read answer late");
  // unmapped reads are refused with slverr and zero data
  property p_r_err; s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h3c
    |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0; endproperty
  a_r_err: assert property (p_r_err) else $error("unmapped read accepted");
  property p_r_ok; s_axi_arvalid && s_axi_arready && s_axi_araddr <= 8'h3c
    |=> s_axi_rresp == 2'b00; endproperty
  a_r_ok: assert property (p_r_ok) else $error("mapped read refused");
  c_fall: cover property ($fell(flow_active_q));
  c_hold: cover property ($rose(hold_annunciator_q));
  c_irq: cover property ($rose(irq_q));
endmodule
bind tcrs_top tcrs_props #(.ACT_CYC(ACT_CYC)) u_props (.clock, .reset_n, .pulse_in,
  .flow_active_q, .hold_annunciator_q, .irq_q, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready);

// >>> tb/tcrs_far.sv
// far-side model: flowmeter pulse train, panel buttons, remote terminals
// assumes commands change just after a rising clock edge
`timescale 1ns/1ps
module tcrs_far (
  input  wire       clock,
  input  wire [7:0] pulse_period,
  input  wire       buttons_held,
  input  wire       terminals_shorted,
  output reg        pulse_in,
  output wire       button_a_n,
  output wire       button_b_n,
  output wire       remote_clear_terminal_a,
  output wire       remote_clear_terminal_b
);
  reg [7:0] phase_q;
  initial begin
    phase_q = 8'h00;
    pulse_in = 1'b0;
  end
  // period zero parks the line low; pulses stay two cycles wide for the sync
  always @(posedge clock) begin
    if (pulse_period == 8'h00 || phase_q >= pulse_period - 8'h01) phase_q <= 8'h00;
    else phase_q <= phase_q + 8'h01;
    pulse_in <= (pulse_period != 8'h00) && (phase_q < 8'h02);
  end
  // both buttons go down together, active low
  assign button_a_n = ~buttons_held;
  assign button_b_n = ~buttons_held;
  // a closed contact shows both terminals high
  assign remote_clear_terminal_a = terminals_shorted;
  assign remote_clear_terminal_b = terminals_shorted;
endmodule

// >>> tb/tb_top.sv
// bench: axi4-lite register traffic plus the far-side model
// assumes shortened hold, activity and gate counts set as parameters
`timescale 1ns/1ps
`include "tcrs_map.vh"
module tb_top;
  reg         clock = 1'b0;
  reg         reset_n = 1'b0;
  reg  [7:0]  per = 8'h00;
  reg         press = 1'b0;
  reg         shrt = 1'b0;
  reg  [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  reg  [31:0] s_axi_wdata = 32'h0;
  reg  [3:0]  s_axi_wstrb = 4'hf;
  reg         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  reg         s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  wire        pulse_in, button_a_n, button_b_n, remote_clear_terminal_a;
  wire        remote_clear_terminal_b, hold_annunciator_q, flow_active_q, irq_q;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  int         err_count = 0, n_tests = 0;
  reg  [31:0] v, t0, g0;
  reg  [1:0]  rr;
  always #20 clock = ~clock;
  tcrs_top #(.ACT_CYC(20), .TOT_CYC(30), .GT_CYC(100), .REM_CYC(10), .GATE_CYC(50)) DUT (
    .clock, .reset_n, .pulse_in, .button_a_n, .button_b_n, .remote_clear_terminal_a,
    .remote_clear_terminal_b, .hold_annunciator_q, .flow_active_q, .irq_q, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  tcrs_far u_far (.clock, .pulse_period(per), .buttons_held(press), .terminals_shorted(shrt),
    .pulse_in, .button_a_n, .button_b_n, .remote_clear_terminal_a, .remote_clear_terminal_b);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input [31:0] s, input [31:0] e);
    n_tests++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  // address and data offered together, each dropped at its own handshake
  task automatic wr(input [7:0] a, input [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    fork
      begin do @(posedge clock); while (!s_axi_awready); s_axi_awvalid <= 1'b0; end
      begin do @(posedge clock); while (!s_axi_wready); s_axi_wvalid <= 1'b0; end
    join
    s_axi_bready <= 1'b1;
    do @(posedge clock); while (!s_axi_bvalid);
    rr = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clock); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge clock); while (!s_axi_rvalid);
    v = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task pr(input int n);
    press <= 1'b1;
    cyc(n);
    press <= 1'b0;
    cyc(5);
  endtask
  task run_flow;
    per <= 8'd5;
    cyc(60);
    per <= 8'd0;
    cyc(10);
  endtask
  task tally_and_finish;
    if (err_count == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task t_reset;
    chk("hold at reset", hold_annunciator_q, 1'b1);
    chk("irq at reset", irq_q, 1'b0);
    rd(8'h40);
    chk("unmapped resp", rr, 2'b10);
    chk("unmapped data", v, 32'h0);
    wr(8'h40, 32'h0);
    chk("unmapped wresp", rr, 2'b10);
  endtask
  // scaling writes (div, scale, timebase, point sit 4 apart) wipe the clip-off
  task t_access;
    wr(`TCRS_CTRL_OFS, 32'h4);
    rd(`TCRS_STAT_OFS);
    chk("open access", v[2], 1'b1);
    for (int i = 0; i < 4; i++) begin
      wr(`TCRS_CLIP_OFS, 32'h7);
      rd(`TCRS_CLIP_OFS);
      chk("clip set", v, 32'h7);
      wr(8'(`TCRS_DIV_OFS + 4 * i), 32'h2);
      rd(`TCRS_CLIP_OFS);
      chk("clip wiped", v, 32'h0);
      wr(8'(`TCRS_DIV_OFS + 4 * i), 32'(i < 2));
    end
    wr(`TCRS_CODE_OFS, 32'h1234);
    rd(`TCRS_STAT_OFS);
    chk("code pending", v[2], 1'b1);
    wr(`TCRS_CTRL_OFS, 32'h0);
    wr(`TCRS_CTRL_OFS, 32'h4);
    rd(`TCRS_STAT_OFS);
    chk("locked", v[2], 1'b0);
    wr(`TCRS_CLIP_OFS, 32'h9);
    rd(`TCRS_CLIP_OFS);
    chk("clip locked", v, 32'h0);
    wr(`TCRS_GATE_OFS, 32'h1234);
    rd(`TCRS_STAT_OFS);
    chk("unlocked", v[2], 1'b1);
  endtask
  // ten pulses per gate, scaled by each timebase, then pushed under clip-off
  task t_rate;
    per <= 8'd5;
    cyc(160);
    chk("active", flow_active_q, 1'b1);
    for (int k = 0; k < 3; k++) begin
      wr(`TCRS_TB_OFS, k);
      cyc(160);
      rd(`TCRS_RATE_OFS);
      chk("rate", v, k == 0 ? 10 : k == 1 ? 600 : 36000);
    end
    chk("flowing", hold_annunciator_q, 1'b0);
    wr(`TCRS_DIV_OFS, 32'h2);
    wr(`TCRS_TB_OFS, 32'h0);
    cyc(160);
    rd(`TCRS_RATE_OFS);
    chk("rate div", v, 32'd5);
    wr(`TCRS_CLIP_OFS, 32'h6);
    cyc(160);
    chk("hold", hold_annunciator_q, 1'b1);
    rd(`TCRS_RATE_OFS);
    chk("rate held", v, 32'h0);
    rd(`TCRS_TOT_OFS);
    t0 = v;
    cyc(120);
    rd(`TCRS_TOT_OFS);
    chk("total held", v, t0);
    per <= 8'd0;
    cyc(40);
    chk("idle", flow_active_q, 1'b0);
  endtask
  task t_irq;
    rd(`TCRS_IRQ_OFS);
    chk("hold event", v[2:0], 3'h4);
    chk("masked", irq_q, 1'b0);
    wr(`TCRS_MASK_OFS, 32'h4);
    cyc(3);
    chk("raised", irq_q, 1'b1);
    wr(`TCRS_IRQ_OFS, 32'h4);
    cyc(3);
    chk("cleared", irq_q, 1'b0);
    wr(`TCRS_CLIP_OFS, 32'h0);
    wr(`TCRS_DIV_OFS, 32'h1);
  endtask
  // a broken closure restarts the timer; a long one clears the total only
  task t_remote;
    wr(`TCRS_CTRL_OFS, 32'h0);
    run_flow;
    rd(`TCRS_TOT_OFS);
    t0 = v;
    chk("counting", t0 != 0, 1'b1);
    rd(`TCRS_GT_LO_OFS);
    g0 = v;
    shrt <= 1'b1;
    cyc(6);
    shrt <= 1'b0;
    cyc(3);
    shrt <= 1'b1;
    cyc(6);
    shrt <= 1'b0;
    cyc(5);
    rd(`TCRS_TOT_OFS);
    chk("short closure", v, t0);
    shrt <= 1'b1;
    cyc(14);
    shrt <= 1'b0;
    cyc(5);
    rd(`TCRS_TOT_OFS);
    chk("remote clear", v, 32'h0);
    rd(`TCRS_GT_LO_OFS);
    chk("grand kept", v, g0);
    rd(`TCRS_IRQ_OFS);
    chk("clear event", v[0], 1'b1);
  endtask
  task t_panel;
    run_flow;
    rd(`TCRS_TOT_OFS);
    t0 = v;
    pr(40);
    rd(`TCRS_TOT_OFS);
    chk("panel off", v, t0);
    wr(`TCRS_CTRL_OFS, 32'h1);
    pr(20);
    rd(`TCRS_TOT_OFS);
    chk("short press", v, t0);
    pr(40);
    rd(`TCRS_TOT_OFS);
    chk("panel clear", v, 32'h0);
    rd(`TCRS_GT_LO_OFS);
    g0 = v;
    pr(110);
    rd(`TCRS_GT_LO_OFS);
    chk("grand off", v, g0);
    wr(`TCRS_CTRL_OFS, 32'h3);
    pr(80);
    rd(`TCRS_GT_LO_OFS);
    chk("grand short", v, g0);
    pr(110);
    rd(`TCRS_GT_LO_OFS);
    chk("grand clear lo", v, 32'h0);
    rd(`TCRS_GT_HI_OFS);
    chk("grand clear hi", v, 32'h0);
  endtask
  // a wrong word must not zero the grand total, the right one must
  task t_menu;
    run_flow;
    rd(`TCRS_GT_LO_OFS);
    g0 = v;
    chk("grand counts", g0 != 0, 1'b1);
    wr(`TCRS_CONFIRM_OFS, {16'h0001, `TCRS_CONFIRM_WORD});
    rd(`TCRS_GT_LO_OFS);
    chk("menu only", v, g0);
    wr(`TCRS_CTRL_OFS, 32'h4);
    wr(`TCRS_CONFIRM_OFS, 32'h1234);
    wr(`TCRS_CONFIRM_OFS, 32'h10000);
    rd(`TCRS_GT_LO_OFS);
    chk("wrong word", v, g0);
    wr(`TCRS_CONFIRM_OFS, {16'h0000, `TCRS_CONFIRM_WORD});
    wr(`TCRS_CONFIRM_OFS, {16'h0001, `TCRS_CONFIRM_WORD});
    rd(`TCRS_GT_LO_OFS);
    chk("menu clear", v, 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(20);
    reset_n <= 1'b1;
    cyc(4);
    t_reset;
    t_access;
    t_rate;
    t_irq;
    t_remote;
    t_panel;
    t_menu;
    tally_and_finish;
  end
  // watchdog: the full sequence needs a few thousand cycles
  initial begin
    cyc(20000);
    err_count++;
    tally_and_finish;
  end
endmodule
